// ==== inc/etcp_pkg.sv ====
package etcp_pkg;
  // Register word index on the internal register port
  typedef logic [1:0] etcp_idx_t;
  // Register data width
  typedef logic [15:0] etcp_word_t;
  // Bus slave data phase state
  typedef enum logic [0:0] {
    etcp_bus_idle,
    etcp_bus_rd_wait
  } etcp_bus_st_t;
endpackage

// ==== inc/etcp_reg_if.sv ====
`timescale 1ns/1ns
// Register port between the bus slave and the timer core
interface etcp_reg_if;
  import etcp_pkg::*;
  logic       wr_stb;
  etcp_idx_t  wr_idx;
  etcp_word_t wr_data;
  etcp_idx_t  rd_idx;
  etcp_word_t rd_data;

  modport bus (
    output wr_stb,
    output wr_idx,
    output wr_data,
    output rd_idx,
    input  rd_data
  );
  modport core (
    input  wr_stb,
    input  wr_idx,
    input  wr_data,
    input  rd_idx,
    output rd_data
  );
endinterface

// ==== inc/etcp_regs.svh ====
`ifndef ETCP_REGS_SVH
`define ETCP_REGS_SVH

// Byte offsets of the four registers on the bus
`define ETCP_OFF_CTRL     32'h0000_0000
`define ETCP_OFF_COUNT    32'h0000_0004
`define ETCP_OFF_RELOAD   32'h0000_0008
`define ETCP_OFF_COMPARE  32'h0000_000c
// Highest mapped byte offset, anything above reads zero
`define ETCP_OFF_LAST     32'h0000_000c

// Word indices taken from address bits 3:2
`define ETCP_IDX_CTRL     2'h0
`define ETCP_IDX_COUNT    2'h1
`define ETCP_IDX_RELOAD   2'h2
`define ETCP_IDX_COMPARE  2'h3

// Control and status bit positions
`define ETCP_B_CPRL       0
`define ETCP_B_GIE        1
`define ETCP_B_RUN        2
`define ETCP_B_EXEN       3
`define ETCP_B_DIRECTION_CONTROL_ENABLE       4
`define ETCP_B_OPE        5
`define ETCP_B_EXF        6
`define ETCP_B_TF         7
`define ETCP_B_PS_LO      8
`define ETCP_B_PS_HI      10
`define ETCP_B_PWMR       11
`define ETCP_B_PWMS       12
`define ETCP_B_CT         15

// Writable configuration bits (flags and reserved bits excluded)
`define ETCP_CTRL_CFG_MASK 16'h9f3f

// Reset values
`define ETCP_RST_CTRL     16'h0000
`define ETCP_RST_COUNT    16'h0000
`define ETCP_RST_RELOAD   16'h0000
`define ETCP_RST_COMPARE  16'h0000

// Prescaler codes and divisor minus one
`define ETCP_PS_DIV1      3'h0
`define ETCP_PS_DIV4      3'h1
`define ETCP_PS_DIV16     3'h2
`define ETCP_PS_DIV64     3'h3
`define ETCP_PS_DIV256    3'h4
`define ETCP_PS_DIV1024   3'h5
`define ETCP_DM1_1        10'h000
`define ETCP_DM1_4        10'h003
`define ETCP_DM1_16       10'h00f
`define ETCP_DM1_64       10'h03f
`define ETCP_DM1_256      10'h0ff
`define ETCP_DM1_1024     10'h3ff

// Count limits
`define ETCP_CNT_ZERO     16'h0000
`define ETCP_CNT_ONE      16'h0001
`define ETCP_CNT_MAX      16'hffff

`endif

// ==== src/etcp_ahb_slave.sv ====
`timescale 1ns/1ns
`include "etcp_regs.svh"
// AHB-Lite slave: writes in zero wait states, reads with one wait state
module etcp_ahb_slave
  import etcp_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // AHB-Lite
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Register port
  etcp_reg_if.bus          regs
);
  etcp_bus_st_t st_ff;
  logic         wr_ph_ff;
  logic         map_ff;
  etcp_idx_t    idx_ff;

  // Address phase decode; hsize is ignored since only words are used
  wire acc     = i_hsel & i_htrans[1] & i_hready;
  wire mapped  = (i_haddr <= `ETCP_OFF_LAST) & (i_haddr[1:0] == 2'h0);
  wire rd_acc  = acc & ~i_hwrite;

  // Register port wiring; write data stands in the data phase
  assign regs.wr_stb  = wr_ph_ff & map_ff;
  assign regs.wr_idx  = idx_ff;
  assign regs.wr_data = i_hwdata[15:0];
  assign regs.rd_idx  = idx_ff;

  // Read waits a cycle so a write just before it is already visible
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_ff       <= etcp_bus_idle;
      wr_ph_ff    <= 1'b0;
      map_ff      <= 1'b0;
      idx_ff      <= `ETCP_IDX_CTRL;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      wr_ph_ff <= acc & i_hwrite;
      if (acc) begin
        map_ff <= mapped;
        idx_ff <= i_haddr[3:2];
      end
      unique case (st_ff)
        etcp_bus_idle: begin
          if (rd_acc) begin
            st_ff       <= etcp_bus_rd_wait;
            o_hreadyout <= 1'b0;
          end
        end
        etcp_bus_rd_wait: begin
          st_ff       <= etcp_bus_idle;
          o_hreadyout <= 1'b1;
          o_hrdata    <= map_ff ? {16'h0000, regs.rd_data} : 32'h0000_0000;
        end
      endcase
    end
  end
endmodule // etcp_ahb_slave

// ==== src/etcp_timer.sv ====
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "etcp_regs.svh"
module etcp_timer
  import etcp_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // First timer pin
  input  wire logic        i_first_pin,
  output logic             o_first_pin,
  output logic             o_first_pin_oe_n,
  // Second timer pin
  input  wire logic        i_second_pin,
  output logic             o_second_pin,
  output logic             o_second_pin_oe_n,
  // Interrupt request
  output logic             o_irq
);
  etcp_reg_if regs ();

  etcp_ahb_slave u_bus (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hsize     (i_hsize),
    .i_hwdata    (i_hwdata),
    .i_hready    (i_hready),
    .o_hrdata    (o_hrdata),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp),
    .regs        (regs)
  );

  // Registers
  etcp_word_t ctrl_ff;
  etcp_word_t cnt_ff;
  etcp_word_t reload_ff;
  etcp_word_t cmp_ff;
  logic       exf_ff;
  logic       exf_irq_ff;
  logic       tf_ff;
  logic       down_ff;
  logic [9:0] ps_ff;
  logic       tba_s1_ff;
  logic       tba_s2_ff;
  logic       tba_s3_ff;
  logic       tbb_s1_ff;
  logic       tbb_s2_ff;
  logic       tbb_s3_ff;
  etcp_word_t nxt_cnt;
  logic       nxt_down;
  logic       ovf;
  logic       nxt_pwm;

  // Control field decode
  wire       cprl  = ctrl_ff[`ETCP_B_CPRL];
  wire       gie   = ctrl_ff[`ETCP_B_GIE];
  wire       run   = ctrl_ff[`ETCP_B_RUN];
  wire       exen  = ctrl_ff[`ETCP_B_EXEN];
  wire       direction_control_enable  = ctrl_ff[`ETCP_B_DIRECTION_CONTROL_ENABLE];
  wire       ope   = ctrl_ff[`ETCP_B_OPE];
  wire [2:0] psel  = ctrl_ff[`ETCP_B_PS_HI:`ETCP_B_PS_LO];
  wire       pwmr  = ctrl_ff[`ETCP_B_PWMR];
  wire       pwms  = ctrl_ff[`ETCP_B_PWMS];
  wire       ct    = ctrl_ff[`ETCP_B_CT];
  wire       pwm   = pwmr | pwms;

  // Register port decode
  wire ctrl_wr   = regs.wr_stb & (regs.wr_idx == `ETCP_IDX_CTRL);
  wire cnt_wr    = regs.wr_stb & (regs.wr_idx == `ETCP_IDX_COUNT);
  wire reload_wr = regs.wr_stb & (regs.wr_idx == `ETCP_IDX_RELOAD);
  wire cmp_wr    = regs.wr_stb & (regs.wr_idx == `ETCP_IDX_COMPARE);
  wire [15:0] wd = regs.wr_data;

  // Status read value carries the flags in their own bit positions
  wire [15:0] stat_rd = ctrl_ff
                      | ({15'h0000, exf_ff} << `ETCP_B_EXF)
                      | ({15'h0000, tf_ff} << `ETCP_B_TF);
  assign regs.rd_data = (regs.rd_idx == `ETCP_IDX_CTRL)   ? stat_rd   :
                        (regs.rd_idx == `ETCP_IDX_COUNT)  ? cnt_ff    :
                        (regs.rd_idx == `ETCP_IDX_RELOAD) ? reload_ff : cmp_ff;

  // Prescaler divisor minus one; unused codes divide by one
  wire [9:0] div_m1 = (psel == `ETCP_PS_DIV4)    ? `ETCP_DM1_4    :
                      (psel == `ETCP_PS_DIV16)   ? `ETCP_DM1_16   :
                      (psel == `ETCP_PS_DIV64)   ? `ETCP_DM1_64   :
                      (psel == `ETCP_PS_DIV256)  ? `ETCP_DM1_256  :
                      (psel == `ETCP_PS_DIV1024) ? `ETCP_DM1_1024 : `ETCP_DM1_1;
  // Compare with >= so a smaller divisor chosen mid-count cannot stall
  wire ps_tick = run & (ps_ff >= div_m1);

  // Pin edges, read only from the second and third sync stages
  wire tba_edge = tba_s2_ff ^ tba_s3_ff;
  wire tbb_fall = ~tbb_s2_ff & tbb_s3_ff;

  // Count source: prescaled clock or first pin transitions
  wire cnt_tick = run & (ct ? tba_edge : ps_tick);

  // Direction: pin level outside PWM, sweep state in PWM
  wire updown   = direction_control_enable & pwm;
  wire dir_down = direction_control_enable & (pwm ? down_ff : ~tbb_s2_ff);
  wire [15:0] top_val = cprl ? `ETCP_CNT_MAX : reload_ff;
  wire [15:0] bot_val = cprl ? `ETCP_CNT_MAX : reload_ff;

  // External edge and its effects
  wire ext_evt  = run & exen & tbb_fall;
  wire force_ld = ext_evt & ~cprl & ~pwm;
  wire capture  = ext_evt & cprl;
  wire exf_set  = ext_evt & (cprl | ~dir_down | pwm);
  wire exf_tog  = ovf & ~cprl & ~pwm;

  // Square wave on the first pin in timer mode only
  wire sq_en    = ope & ~ct;

  // Compare and period matches on the value the count moves to
  wire upd      = nxt_cnt != cnt_ff;
  wire match_c  = upd & (nxt_cnt == cmp_ff);
  wire match_r  = upd & (nxt_cnt == reload_ff);

  // Next count; software write beats pin reload beats counting
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_down = updown & down_ff;
    ovf      = 1'b0;
    if (cnt_wr) begin
      nxt_cnt = wd;
    end else if (force_ld) begin
      nxt_cnt = dir_down ? reload_ff : `ETCP_CNT_ZERO;
    end else if (cnt_tick) begin
      if (!dir_down) begin
        if (cnt_ff == top_val) begin
          ovf = 1'b1;
          if (updown) begin
            nxt_down = 1'b1;
            nxt_cnt  = cnt_ff - `ETCP_CNT_ONE;
          end else begin
            nxt_cnt  = `ETCP_CNT_ZERO;
          end
        end else begin
          nxt_cnt = cnt_ff + `ETCP_CNT_ONE;
        end
      end else if (cnt_ff == `ETCP_CNT_ZERO) begin
        ovf = 1'b1;
        if (updown) begin
          nxt_down = 1'b0;
          nxt_cnt  = `ETCP_CNT_ONE;
        end else begin
          nxt_cnt  = bot_val;
        end
      end else begin
        nxt_cnt = cnt_ff - `ETCP_CNT_ONE;
      end
    end
  end

  // PWM level on the second pin
  always_comb begin
    nxt_pwm = o_second_pin;
    if (pwmr & pwms) begin
      if (match_c) nxt_pwm = ~o_second_pin;
    end else if (pwmr) begin
      if (match_c) nxt_pwm = 1'b0;
      else if (match_r) nxt_pwm = 1'b1;
    end else if (pwms) begin
      if (match_c) nxt_pwm = 1'b1;
      else if (match_r) nxt_pwm = 1'b0;
    end
  end

  // Pin synchronisers
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      tba_s1_ff <= 1'b1;
      tba_s2_ff <= 1'b1;
      tba_s3_ff <= 1'b1;
      tbb_s1_ff <= 1'b1;
      tbb_s2_ff <= 1'b1;
      tbb_s3_ff <= 1'b1;
    end else begin
      tba_s1_ff <= i_first_pin;
      tba_s2_ff <= tba_s1_ff;
      tba_s3_ff <= tba_s2_ff;
      tbb_s1_ff <= i_second_pin;
      tbb_s2_ff <= tbb_s1_ff;
      tbb_s3_ff <= tbb_s2_ff;
    end
  end

  // Software registers; capture beats a software write of the period
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ctrl_ff   <= `ETCP_RST_CTRL;
      cnt_ff    <= `ETCP_RST_COUNT;
      reload_ff <= `ETCP_RST_RELOAD;
      cmp_ff    <= `ETCP_RST_COMPARE;
      ps_ff     <= `ETCP_DM1_1;
      down_ff   <= 1'b0;
    end else begin
      if (ctrl_wr) ctrl_ff <= wd & `ETCP_CTRL_CFG_MASK;
      if (capture) reload_ff <= cnt_ff;
      else if (reload_wr) reload_ff <= wd;
      if (cmp_wr) cmp_ff <= wd;
      cnt_ff  <= nxt_cnt;
      down_ff <= nxt_down;
      if (run) ps_ff <= ps_tick ? `ETCP_DM1_1 : ps_ff + 10'h001;
    end
  end

  // Flags: a hardware set wins over a software write in the same cycle
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      exf_ff     <= 1'b0;
      exf_irq_ff <= 1'b0;
      tf_ff      <= 1'b0;
    end else begin
      if (exf_set) exf_ff <= 1'b1;
      else if (exf_tog) exf_ff <= ~exf_ff;
      else if (ctrl_wr) exf_ff <= wd[`ETCP_B_EXF];
      // Only qualifying edges may request an interrupt
      if (exf_set) exf_irq_ff <= 1'b1;
      else if (ctrl_wr & ~wd[`ETCP_B_EXF]) exf_irq_ff <= 1'b0;
      if (ovf) tf_ff <= 1'b1;
      else if (ctrl_wr) tf_ff <= wd[`ETCP_B_TF];
    end
  end

  // Pin drivers and interrupt, all registered
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_first_pin       <= 1'b0;
      o_first_pin_oe_n  <= 1'b1;
      o_second_pin      <= 1'b1;
      o_second_pin_oe_n <= 1'b1;
      o_irq             <= 1'b0;
    end else begin
      if (ovf & sq_en) o_first_pin <= ~o_first_pin;
      o_first_pin_oe_n  <= ~sq_en;
      o_second_pin      <= nxt_pwm;
      o_second_pin_oe_n <= ~pwm;
      o_irq             <= gie & (tf_ff | exf_irq_ff);
    end
  end

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  irq_gate_a: assert property (
    !gie |=> !o_irq) else $error("interrupt raised while disabled");
  irq_cause_a: assert property (
    gie && tf_ff |=> o_irq) else $error("pending overflow gave no interrupt");
  stop_hold_a: assert property (
    !run && !regs.wr_stb |=> $stable(cnt_ff) && $stable(ps_ff) && $stable(tf_ff))
    else $error("stopped timer changed state");
  up_wrap_a: assert property (
    cnt_tick && !dir_down && !updown && !cprl && cnt_ff == reload_ff && !cnt_wr && !force_ld
    |=> cnt_ff == `ETCP_CNT_ZERO && tf_ff) else $error("up count did not wrap at period");
  down_load_a: assert property (
    cnt_tick && dir_down && !updown && !cprl && cnt_ff == `ETCP_CNT_ZERO && !cnt_wr && !force_ld
    |=> cnt_ff == $past(reload_ff)) else $error("down count did not load period");
  capture_a: assert property (
    capture |=> reload_ff == $past(cnt_ff)) else $error("capture missed");
  tf_sticky_a: assert property (
    tf_ff && !ctrl_wr |=> tf_ff) else $error("overflow flag cleared by hardware");
  pwm_drive_a: assert property (
    pwm ##1 pwm |-> !o_second_pin_oe_n) else $error("second pin not driven in pwm");
  pwm_reset_a: assert property (
    pwmr && !pwms && match_c |=> !o_second_pin) else $error("reset pwm not low at compare");
  square_a: assert property (
    ovf && sq_en |=> o_first_pin != $past(o_first_pin)) else $error("square wave missed");
endmodule // etcp_timer

// ==== tb/enhanced_timer_capture_pwm_test.sv ====
`timescale 1ns/1ns
module enhanced_timer_capture_pwm_test;
  import etcp_pkg::*;
  logic        clock, nrst, hsel, hwrite, fp_ext, sp_ext;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic        hready, hresp, fp_o, fp_oe_n, sp_o, sp_oe_n, fp, sp, irq;
  int          fails, total_checks;
  logic [15:0] q, a;
  int          h;

  // Free-running 100 MHz clock
  always #5 clock = ~clock;

  // Device under test, alone on the bus so its ready is the bus ready
  etcp_timer u_etcp_timer (.i_clock(clock), .i_nrst(nrst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_first_pin(fp), .o_first_pin(fp_o), .o_first_pin_oe_n(fp_oe_n),
    .i_second_pin(sp), .o_second_pin(sp_o), .o_second_pin_oe_n(sp_oe_n), .o_irq(irq));
  // Pads on both timer pins
  etcp_pin_model u_pin_a (.i_oe_n(fp_oe_n), .i_dev(fp_o), .i_ext(fp_ext), .o_level(fp));
  etcp_pin_model u_pin_b (.i_oe_n(sp_oe_n), .i_dev(sp_o), .i_ext(sp_ext), .o_level(sp));

  task final_report;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One single transfer; a stuck bus ends the run rather than hanging it
  task xfer(input logic w, input logic [7:0] ad, input logic [15:0] d,
            output logic [15:0] r);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= w;
    n = 0;
    do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 40);
    r = hrdata[15:0];
    if (n >= 40) begin
      fails++;
      final_report;
    end
  endtask

  task wr(input logic [7:0] ad, input logic [15:0] d);
    logic [15:0] r;
    xfer(1'b1, ad, d, r);
  endtask

  task rd(input logic [7:0] ad, output logic [15:0] r);
    xfer(1'b0, ad, 16'h0, r);
  endtask

  // Falling pulse on the second pin, long enough for the synchroniser
  task pulse_b;
    sp_ext <= 1'b0;
    wt(6);
    sp_ext <= 1'b1;
    wt(6);
  endtask

  task t_reset;
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4), q);
      chk("reg_reset", {16'h0, q}, 32'h0);
    end
    chk("hresp", {31'h0, hresp}, 32'h0);
    // Read-back shows all 16 bits and zeros above them
    wr(8'h0c, 16'ha5c3);
    rd(8'h0c, q);
    chk("cmp_rdback", hrdata, 32'h0000_a5c3);
  endtask

  // Square wave: period 5 counts, so 20 pin toggles in 100 cycles
  task t_square;
    wr(8'h08, 16'h0004);
    wr(8'h00, 16'h0024);
    wt(10);
    h = 0;
    repeat (100) begin
      a[0] = fp_o;
      @(posedge clock);
      if (fp_o !== a[0]) h++;
    end
    chk("sq_toggles", h, 20);
    chk("fp_oe_n", {31'h0, fp_oe_n}, 32'h0);
    // Flag read while running, before any write could set it
    rd(8'h00, q);
    chk("tf_sticky", {31'h0, q[7]}, 32'h1);
    wr(8'h00, 16'h00a0);
    rd(8'h04, a);
    wt(20);
    rd(8'h04, q);
    chk("frozen", {16'h0, q}, {16'h0, a});
    wr(8'h00, 16'h0000);
    wt(3);
    chk("fp_release", {31'h0, fp_oe_n}, 32'h1);
  endtask

  // Each prescaler code against its divisor over a 4096-cycle run
  task t_presc;
    int dv[8] = '{1, 4, 16, 64, 256, 1024, 1, 1};
    int e;
    wr(8'h08, 16'hffff);
    for (int k = 0; k < 8; k++) begin
      wr(8'h04, 16'h0000);
      wr(8'h00, 16'h0004 | 16'(k << 8));
      wt(4096);
      wr(8'h00, 16'(k << 8));
      rd(8'h04, q);
      e = 4098 / dv[k];
      chk("presc", {31'h0, (int'(q) + 2 >= e) && (int'(q) <= e + 2)}, 32'h1);
    end
  endtask

  task t_capture;
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h1000);
    wr(8'h00, 16'h000f);
    pulse_b;
    rd(8'h08, q);
    chk("capture", {31'h0, q >= 16'h1000 && q < 16'h1100}, 32'h1);
    rd(8'h00, q);
    chk("exf_cap", {31'h0, q[6]}, 32'h1);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(8'h00, 16'h000e);
    wt(3);
    chk("irq_off", {31'h0, irq}, 32'h0);
    wr(8'h00, 16'h000d);
    pulse_b;
    rd(8'h00, q);
    chk("exf_nogie", {31'h0, q[6]}, 32'h1);
    chk("irq_masked", {31'h0, irq}, 32'h0);
  endtask

  // Period 9, compare 4: half the ten-count cycle is high in set and reset modes, half of two cycles when toggling
  task t_pwm;
    logic [15:0] m[3] = '{16'h0804, 16'h1004, 16'h1804};
    wr(8'h08, 16'h0009);
    wr(8'h0c, 16'h0004);
    for (int k = 0; k < 3; k++) begin
      wr(8'h04, 16'h0000);
      wr(8'h00, m[k]);
      wt(30);
      h = 0;
      repeat (200) begin
        @(posedge clock);
        if (sp_o === 1'b1) h++;
      end
      chk("pwm_duty", h, 100);
      chk("sp_oe_n", {31'h0, sp_oe_n}, 32'h0);
      wr(8'h00, m[k] & 16'hfffb);
      rd(8'h04, q);
      a[0] = (q >= 16'h0004 && q < 16'h0009) ? (k == 1) : (k == 0);
      if (k < 2) chk("pwm_level", {31'h0, sp_o}, {31'h0, a[0]});
    end
    wr(8'h00, 16'h0000);
  endtask

  // Direction pin low makes the count fall through zero into the period
  task t_dir;
    wr(8'h08, 16'h0100);
    wr(8'h04, 16'h0010);
    sp_ext <= 1'b0;
    wt(6);
    wr(8'h00, 16'h0014);
    wt(50);
    wr(8'h00, 16'h0010);
    rd(8'h04, q);
    chk("count_down", {31'h0, q < 16'h0100 && q > 16'h00c0}, 32'h1);
    sp_ext <= 1'b1;
    wt(6);
  endtask

  // Counter mode: ten first-pin transitions give a count of ten
  task t_counter;
    wr(8'h08, 16'hffff);
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h8004);
    repeat (10) begin
      fp_ext <= ~fp_ext;
      wt(6);
    end
    wt(6);
    rd(8'h04, q);
    chk("ext_count", {16'h0, q}, 32'ha);
  endtask

  task t_pinreload;
    wr(8'h04, 16'h0500);
    wr(8'h00, 16'h000c);
    pulse_b;
    // Flag read before the stop write, which would clear it
    rd(8'h00, q);
    chk("exf_reload", {31'h0, q[6]}, 32'h1);
    wr(8'h00, 16'h0008);
    rd(8'h04, q);
    chk("pin_reload", {31'h0, q < 16'h0020}, 32'h1);
  endtask

  // Period zero overflows every tick: flag toggles but never interrupts
  task t_toggle;
    logic [15:0] b;
    wr(8'h08, 16'h0000);
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h0004);
    rd(8'h00, a);
    rd(8'h00, b);
    chk("exf_toggle", {31'h0, a[6] ^ b[6]}, 32'h1);
    wr(8'h00, 16'h00c0);
    wr(8'h00, 16'h0042);
    wt(3);
    chk("exf_no_irq", {31'h0, irq}, 32'h0);
    wr(8'h00, 16'h0000);
  endtask

  // Main sequence
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fp_ext = 1'b0;
    sp_ext = 1'b1;
    fails = 0;
    total_checks = 0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset;
    t_square;
    t_presc;
    t_capture;
    t_pwm;
    t_dir;
    t_counter;
    t_pinreload;
    t_toggle;
    final_report;
  end
endmodule // enhanced_timer_capture_pwm_test

// ==== tb/etcp_pin_model.sv ====
`timescale 1ns/1ns
// Far side of one timer pin: yields whenever the device drives the pad
module etcp_pin_model (
  // Pad state
  input  wire logic i_oe_n,
  input  wire logic i_dev,
  input  wire logic i_ext,
  // Resolved level
  output logic      o_level
);
  // Low enable means the device owns the wire
  assign o_level = i_oe_n ? i_ext : i_dev;
endmodule // etcp_pin_model
